// *** design/dma_chan_pkg.sv ***
package dma_chan_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ctrl_off  = 4'h0;
  localparam logic [3:0] stat_off  = 4'h4;
  localparam logic [3:0] count_off = 4'h8;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int start_bit      = 31;
  localparam int normal_ie_bit  = 23;
  localparam int abnorm_ie_bit  = 22;
  localparam int beat_width_lsb = 2;
  localparam int io_width_lsb   = 0;

  // ****************************************
  // Status fields
  // ****************************************
  localparam int ready_bit     = 31;
  localparam int normal_bit    = 23;
  localparam int abnormal_bit  = 22;
  localparam int src_err_bit   = 20;
  localparam int dst_err_bit   = 19;
  localparam int setup_err_bit = 18;

  localparam logic [31:0] ctrl_reset  = 32'h0000_0000;
  localparam logic [1:0]  resp_okay   = 2'h0;
  localparam logic [1:0]  resp_slverr = 2'h2;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_run  = 1'b1
  } chan_state_e;

  typedef struct packed {
    logic       src_err;
    logic       dst_err;
  } xfer_err_s;

  typedef logic [2:0] bytes_t;

endpackage

// *** design/dma_channel_size_and_status.sv ***
`timescale 1ns/1ns

module dma_channel_size_and_status
#(
  parameter int count_w = 24
)
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output      logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output      logic               s_axi_wready,
  output      logic [1:0]         s_axi_bresp,
  output      logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output      logic               s_axi_arready,
  output      logic [31:0]        s_axi_rdata,
  output      logic [1:0]         s_axi_rresp,
  output      logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output      logic               beat_req,
  output      dma_chan_pkg::bytes_t beat_bytes,
  output      dma_chan_pkg::bytes_t io_port_bytes,
  input  wire logic               beat_ack,
  input  wire dma_chan_pkg::xfer_err_s beat_err,
  output      logic               irq_normal,
  output      logic               irq_abnormal
);

  // ****************************************
  // Storage
  // ****************************************
  logic [31:0]               ctrl;
  logic [count_w-1:0]        count;
  logic                      normal_done;
  logic                      abnormal_done;
  logic                      src_err;
  logic                      dst_err;
  logic                      setup_err;
  dma_chan_pkg::chan_state_e state;
  logic                      aw_held;
  logic                      w_held;
  logic [3:0]                aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;

  // Width code to byte count: 11 one byte, 10 two bytes, 0x four bytes
  function automatic dma_chan_pkg::bytes_t width_bytes(input logic [1:0] code);
    width_bytes = code[1] ? (code[0] ? 3'h1 : 3'h2) : 3'h4;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire wr_fire    = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl    = wr_fire && aw_addr == dma_chan_pkg::ctrl_off;
  wire wr_stat    = wr_fire && aw_addr == dma_chan_pkg::stat_off;
  wire wr_count   = wr_fire && aw_addr == dma_chan_pkg::count_off;
  wire wr_mapped  = wr_ctrl || wr_stat || wr_count;
  wire start_req  = wr_ctrl && w_strb[3] && w_data[dma_chan_pkg::start_bit];
  wire flags_busy = normal_done || abnormal_done;
  wire start_bad  = start_req && flags_busy;
  wire start_ok   = start_req && !flags_busy && state == dma_chan_pkg::st_idle;
  // Only a zero in an enabled lane clears; a one has no effect
  wire clr_normal = wr_stat && w_strb[2] && !w_data[dma_chan_pkg::normal_bit];
  wire clr_abnorm = wr_stat && w_strb[2] && !w_data[dma_chan_pkg::abnormal_bit];

  // Control word as it stands after this write, so a start sees its own widths
  logic [31:0] next_ctrl;
  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    assign next_ctrl[8*g +: 8] = (wr_ctrl && w_strb[g]) ? w_data[8*g +: 8] : ctrl[8*g +: 8];
  end

  wire                  beat_done  = beat_req && beat_ack;
  wire                  beat_fail  = beat_done && (beat_err.src_err || beat_err.dst_err);
  wire [count_w-1:0]    step       = count_w'(beat_bytes);
  wire                  last_beat  = count <= step;
  wire                  set_normal = beat_done && !beat_fail && last_beat;
  wire                  set_abnorm = beat_fail || start_bad;

  wire [31:0] status_word =
    {(state == dma_chan_pkg::st_run), 7'h00, normal_done, abnormal_done, 1'b0,
     src_err, dst_err, setup_err, 18'h00000};

  wire        rd_ctrl  = s_axi_araddr == dma_chan_pkg::ctrl_off;
  wire        rd_stat  = s_axi_araddr == dma_chan_pkg::stat_off;
  wire        rd_count = s_axi_araddr == dma_chan_pkg::count_off;
  wire [31:0] rd_word  = rd_ctrl  ? {1'b0, ctrl[30:0]} :
                         rd_stat  ? status_word :
                         rd_count ? 32'(count) : 32'h0000_0000;
  wire        rd_ok    = rd_ctrl || rd_stat || rd_count;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign beat_req      = state == dma_chan_pkg::st_run;
  assign irq_normal    = normal_done && ctrl[dma_chan_pkg::normal_ie_bit];
  assign irq_abnormal  = abnormal_done && ctrl[dma_chan_pkg::abnorm_ie_bit];

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dma_chan_pkg::resp_okay;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? dma_chan_pkg::resp_okay : dma_chan_pkg::resp_slverr;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dma_chan_pkg::resp_okay;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? dma_chan_pkg::resp_okay : dma_chan_pkg::resp_slverr;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // Control and count
  // ****************************************
  // Start bit is a strobe; it is stored in ctrl but masked on read, so it reads back as zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ctrl <= dma_chan_pkg::ctrl_reset;
    else if (wr_ctrl)
      ctrl <= next_ctrl;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      count <= '0;
    else if (beat_done && !beat_fail)
      count <= last_beat ? '0 : count - step;
    else if (wr_count && state == dma_chan_pkg::st_idle)
      count <= w_data[count_w-1:0];
  end

  // Widths are latched at start so a rewrite mid-run cannot tear a beat
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      beat_bytes    <= 3'h4;
      io_port_bytes <= 3'h4;
    end
    else if (start_ok)
    begin
      beat_bytes    <= width_bytes(next_ctrl[dma_chan_pkg::beat_width_lsb +: 2]);
      io_port_bytes <= width_bytes(next_ctrl[dma_chan_pkg::io_width_lsb +: 2]);
    end
  end

  // ****************************************
  // Channel engine
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state <= dma_chan_pkg::st_idle;
    else
    begin
      unique case (state)
        dma_chan_pkg::st_idle:
          if (start_ok)
            state <= dma_chan_pkg::st_run;
        dma_chan_pkg::st_run:
          if (set_normal || beat_fail)
            state <= dma_chan_pkg::st_idle;
      endcase
    end
  end

  // ****************************************
  // Completion flags
  // ****************************************
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      normal_done   <= 1'b0;
      abnormal_done <= 1'b0;
      src_err       <= 1'b0;
      dst_err       <= 1'b0;
      setup_err     <= 1'b0;
    end
    else
    begin
      if (set_normal)
        normal_done <= 1'b1;
      else if (clr_normal)
        normal_done <= 1'b0;
      if (set_abnorm)
        abnormal_done <= 1'b1;
      else if (clr_abnorm)
      begin
        abnormal_done <= 1'b0;
        src_err       <= 1'b0;
        dst_err       <= 1'b0;
        setup_err     <= 1'b0;
      end
      if (beat_fail && beat_err.src_err)
        src_err <= 1'b1;
      if (beat_fail && beat_err.dst_err)
        dst_err <= 1'b1;
      if (start_bad)
        setup_err <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_illegal_start_flags: assert property (start_bad |=> abnormal_done && setup_err)
    else $error("Illegal start did not raise setup error");
  a_illegal_start_idle: assert property (start_bad && state == dma_chan_pkg::st_idle
    |=> !beat_req)
    else $error("Illegal start began a transfer");
  a_abnormal_start: assert property (start_req && abnormal_done |=> setup_err)
    else $error("Start with abnormal flag set not refused");
  a_normal_set: assert property (set_normal |=> normal_done && !beat_req)
    else $error("Normal completion not flagged");
  a_normal_clear: assert property (clr_normal && !set_normal |=> !normal_done && !irq_normal)
    else $error("Normal flag or interrupt not cleared");
  a_one_keeps_flag: assert property (wr_stat && w_strb[2] && w_data[dma_chan_pkg::normal_bit]
    && normal_done |=> normal_done)
    else $error("Writing one changed normal flag");
  a_abn_clear_errs: assert property (clr_abnorm && !set_abnorm && !beat_done
    |=> !abnormal_done && !src_err && !dst_err && !setup_err)
    else $error("Abnormal clear left error flags");
  a_abn_irq_gate: assert property (clr_abnorm && !set_abnorm |=> !irq_abnormal)
    else $error("Abnormal interrupt not withdrawn");
  a_bus_fail_abn: assert property (beat_fail |=> abnormal_done && !beat_req)
    else $error("Bus error did not end abnormally");
  a_beat_size: assert property (start_ok && next_ctrl[3:2] == 2'h3 |=> beat_bytes == 3'h1)
    else $error("Byte beat size wrong");
  a_ready_bit: assert property (start_ok |=> status_word[dma_chan_pkg::ready_bit])
    else $error("Ready bit not shown while running");
  a_port_width: assert property (start_ok && next_ctrl[1:0] == 2'h2 |=> io_port_bytes == 3'h2)
    else $error("Port width wrong");
  a_write_resp: assert property (wr_fire |=> s_axi_bvalid)
    else $error("Write response missing");

  c_normal_run: cover property (start_ok ##[1:40] set_normal);
  c_bus_error: cover property (start_ok ##[1:40] beat_fail);
  c_bad_start: cover property (start_bad);
  c_clear_race: cover property (set_normal && clr_normal);

endmodule

// *** dv/beat_partner.sv ***
`timescale 1ns/1ns

// ****************************************
// Far-side beat responder
// ****************************************
module beat_partner
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      beat_req,
  input  wire logic [3:0]                dly,
  input  wire dma_chan_pkg::xfer_err_s   err_in,
  output      logic                      beat_ack,
  output      dma_chan_pkg::xfer_err_s   beat_err
);
  logic [3:0] wait_cnt;

  // Slow answers stretch each beat so a run can be seen from the bus
  always_ff @(posedge clk)
  begin
    if (!nrst || !beat_req || beat_ack)
      wait_cnt <= 4'h0;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end

  assign beat_ack = beat_req && (wait_cnt == dly);
  // Outside an ack the error lines carry the inverse, never a stale copy
  assign beat_err = beat_ack ? err_in : ~err_in;
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
  typedef struct packed {logic [3:0] code; logic [2:0] beat; logic [2:0] io;} row_s;
  logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0, dly = 4'hf;
  logic [31:0] wd = 32'h0, d, rdat;
  logic [1:0] r, br, bresp, rresp;
  logic awr, wr_rdy, bv, arr, rv, beat_req, beat_ack, irq_normal, irq_abnormal;
  dma_chan_pkg::bytes_t beat_bytes, io_port_bytes;
  dma_chan_pkg::xfer_err_s beat_err, err_in = 2'h0;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_beats = 0;
  int b;
  row_s rows[4] = '{'{4'he, 3'h1, 3'h2}, '{4'hb, 3'h2, 3'h1},
                    '{4'h1, 3'h4, 3'h4}, '{4'h4, 3'h4, 3'h4}};

  always #20 clk = ~clk;
  always @(posedge clk) if (beat_req && beat_ack) n_beats <= n_beats + 1;

  dma_channel_size_and_status u_dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .beat_req(beat_req), .beat_bytes(beat_bytes), .io_port_bytes(io_port_bytes),
    .beat_ack(beat_ack), .beat_err(beat_err), .irq_normal(irq_normal),
    .irq_abnormal(irq_abnormal));

  beat_partner u_far (.clk(clk), .nrst(nrst), .beat_req(beat_req), .dly(dly),
    .err_in(err_in), .beat_ack(beat_ack), .beat_err(beat_err));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv);
    br = bresp;
    bre <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rresp;
    rre <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for beat_req to reach a level; a bound on the wait catches a channel that never ends
  task automatic wait_req(input logic v);
    int k;
    k = 0;
    while (beat_req !== v && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 400) chk(32'h1, 32'h0);
  endtask

  task automatic go(input logic [3:0] code);
    wr(dma_chan_pkg::count_off, 32'h4);
    wr(dma_chan_pkg::ctrl_off, 32'h80c0_0000 | {28'h0, code});
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(dma_chan_pkg::stat_off);
    chk(d, 32'h0);
    chk(32'(io_port_bytes), 32'h4);
    chk({30'h0, irq_normal, irq_abnormal}, 32'h0);
    foreach (rows[i])
    begin
      go(rows[i].code);
      wait_req(1'b1);
      chk(32'(beat_bytes), 32'(rows[i].beat));
      chk(32'(io_port_bytes), 32'(rows[i].io));
      rd(dma_chan_pkg::stat_off);
      chk(d, 32'h8000_0000);
      wait_req(1'b0);
      rd(dma_chan_pkg::stat_off);
      chk(d, 32'h0080_0000);
      chk(32'(irq_normal), 32'h1);
      wr(dma_chan_pkg::stat_off, 32'hffff_ffff);
      rd(dma_chan_pkg::stat_off);
      chk(d, 32'h0080_0000);
      wr(dma_chan_pkg::stat_off, 32'h0);
      rd(dma_chan_pkg::stat_off);
      chk(d, 32'h0);
      chk(32'(irq_normal), 32'h0);
    end
    dly <= 4'h0;
    go(4'h0);
    wait_req(1'b0);
    b = n_beats;
    go(4'h0);
    repeat (4) @(posedge clk);
    chk(32'(n_beats), 32'(b));
    rd(dma_chan_pkg::stat_off);
    chk(d, 32'h00c4_0000);
    chk(32'(irq_abnormal), 32'h1);
    wr(dma_chan_pkg::stat_off, 32'h0040_0000);
    rd(dma_chan_pkg::stat_off);
    chk(d, 32'h0044_0000);
    go(4'h0);
    repeat (4) @(posedge clk);
    chk(32'(n_beats), 32'(b));
    wr(dma_chan_pkg::stat_off, 32'h0);
    rd(dma_chan_pkg::stat_off);
    chk(d, 32'h0);
    chk(32'(irq_abnormal), 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      err_in <= i ? 2'h1 : 2'h2;
      go(4'h0);
      wait_req(1'b0);
      rd(dma_chan_pkg::stat_off);
      chk(d, i ? 32'h0048_0000 : 32'h0050_0000);
      chk(32'(irq_abnormal), 32'h1);
      wr(dma_chan_pkg::stat_off, 32'h0080_0000);
      rd(dma_chan_pkg::stat_off);
      chk(d, 32'h0);
    end
    err_in <= 2'h0;
    rd(4'hc);
    chk(d, 32'h0);
    chk(32'(r), 32'(dma_chan_pkg::resp_slverr));
    wr(4'hc, 32'h0);
    chk(32'(br), 32'(dma_chan_pkg::resp_slverr));
    wr(dma_chan_pkg::count_off, 32'h4);
    chk(32'(br), 32'(dma_chan_pkg::resp_okay));
    // The normal interrupt stays quiet with its enable off, then follows the enable
    wr(dma_chan_pkg::ctrl_off, 32'h8000_0000);
    wait_req(1'b0);
    rd(dma_chan_pkg::stat_off);
    chk(d, 32'h0080_0000);
    chk(32'(irq_normal), 32'h0);
    wr(dma_chan_pkg::ctrl_off, 32'h0080_000a);
    chk(32'(irq_normal), 32'h1);
    rd(dma_chan_pkg::ctrl_off);
    chk(d, 32'h0080_000a);
    wr(dma_chan_pkg::stat_off, 32'h0);
    // Reset in the middle of a slow run
    dly <= 4'hf;
    go(4'he);
    wait_req(1'b1);
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({29'h0, beat_req, irq_normal, irq_abnormal}, 32'h0);
    chk(32'(beat_bytes), 32'h4);
    chk(32'(io_port_bytes), 32'h4);
    rd(dma_chan_pkg::stat_off);
    chk(d, 32'h0);
    rd(dma_chan_pkg::ctrl_off);
    chk(d, 32'(dma_chan_pkg::ctrl_reset));
    summarize;
  end
endmodule
